// file: ccr_regs.sv
// charger control register bank 03h..06h with host watchdog
`timescale 1ns/100ps
`default_nettype none

module ccr_regs #(
   parameter logic [ccr_pkg::WD_CNT_W-1:0] WD_BASE_CYCLES =
      ccr_pkg::WD_BASE_CYCLES // cycles in the shortest period
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_reg_rst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_opt_started,
   input wire logic i_detect_done,
   input wire logic [ccr_pkg::LIMIT_W-1:0] i_opt_result_code,
   input wire logic [ccr_pkg::LIMIT_W-1:0] i_pin_limit_code,
   input wire logic [ccr_pkg::LIMIT_W-1:0] i_detect_limit_code,
   input wire logic i_input_reg,
   input wire logic i_thermal_reg,
   output ccr_pkg::ccr_cfg_type o_cfg,
   output logic [7:0] o_rd_data,
   output logic [ccr_pkg::LIMIT_W-1:0] o_applied_limit,
   output logic o_wd_expired,
   output logic o_timer_slow
);

   // restore the masked bits of a byte to their default
   function automatic logic [7:0] restore_bits(input logic [7:0] cur,
      input logic [7:0] dflt, input logic [7:0] mask);
      restore_bits = (cur & ~mask) | (dflt & mask);
   endfunction

   // watchdog period in cycles, last count of the period
   function automatic logic [ccr_pkg::WD_CNT_W-1:0] wd_last(
      input ccr_pkg::ccr_wd_period_type per);
      unique case (per)
         ccr_pkg::CCR_WD_OFF: wd_last = '0;
         ccr_pkg::CCR_WD_40S: wd_last = WD_BASE_CYCLES - ccr_pkg::WD_CNT_ONE;
         ccr_pkg::CCR_WD_80S: wd_last = (WD_BASE_CYCLES << 1)
            - ccr_pkg::WD_CNT_ONE;
         ccr_pkg::CCR_WD_160S: wd_last = (WD_BASE_CYCLES << 2)
            - ccr_pkg::WD_CNT_ONE;
      endcase
   endfunction

   // byte presented for a host read
   function automatic logic [7:0] read_byte(input logic [7:0] addr,
      input ccr_pkg::ccr_cfg_type cfg);
      case (addr)
         ccr_pkg::ADDR_INPUT_CURRENT: read_byte = cfg.in_cur;
         ccr_pkg::ADDR_PRE_END_CURRENT: read_byte = cfg.pre_end;
         ccr_pkg::ADDR_CTRL_FIRST: read_byte = cfg.ctrl1;
         ccr_pkg::ADDR_CTRL_SECOND:
            read_byte = cfg.ctrl2 & ccr_pkg::RW_MASK_CTRL_SECOND; // R19
         default: read_byte = ccr_pkg::READ_UNMAPPED; // unmapped
      endcase
   endfunction

   ccr_pkg::ccr_core_state_type state_ff; // all block state
   ccr_pkg::ccr_core_state_type nxt_state;
   ccr_pkg::ccr_input_current_type wr_in_cur; // write data as 03h
   ccr_pkg::ccr_limit_src_type limit_src; // minimum selector inputs
   logic host_access; // any read or write counts
   logic [ccr_pkg::WD_CNT_W-1:0] wd_end; // last count of the period

   assign host_access = i_wr_en | i_rd_en;
   assign wd_end = wd_last(state_ff.cfg.ctrl1.wd_period); // R14
   assign wr_in_cur = i_wr_data;

   // next state: clears, watchdog, writes, reads, register reset
   always_comb begin
      nxt_state = state_ff;
      nxt_state.wd_expired = 1'b0;
      // engines acknowledge the kicks
      if (i_opt_started) begin
         nxt_state.cfg.in_cur.optimizer_kick = 1'b0; // R2
      end
      if (i_detect_done) begin
         nxt_state.cfg.in_cur.source_detect_kick = 1'b0; // R3
      end
      // host watchdog, restarted by every access
      if (state_ff.cfg.ctrl1.wd_period == ccr_pkg::CCR_WD_OFF
         || host_access) begin
         nxt_state.wd_count = '0; // R14 R22
      end else if (state_ff.wd_count >= wd_end) begin
         // expiry: listed bits go back to default, limit kept
         nxt_state.wd_count = '0;
         nxt_state.wd_expired = 1'b1;
         nxt_state.cfg.in_cur = restore_bits(nxt_state.cfg.in_cur,
            ccr_pkg::RST_INPUT_CURRENT,
            ccr_pkg::WD_MASK_INPUT_CURRENT); // R5
         nxt_state.cfg.pre_end = restore_bits(state_ff.cfg.pre_end,
            ccr_pkg::RST_PRE_END_CURRENT,
            ccr_pkg::WD_MASK_PRE_END_CURRENT);
         nxt_state.cfg.ctrl1 = restore_bits(state_ff.cfg.ctrl1,
            ccr_pkg::RST_CTRL_FIRST, ccr_pkg::WD_MASK_CTRL_FIRST);
         nxt_state.cfg.ctrl2 = restore_bits(state_ff.cfg.ctrl2,
            ccr_pkg::RST_CTRL_SECOND, ccr_pkg::WD_MASK_CTRL_SECOND);
      end else begin
         nxt_state.wd_count = state_ff.wd_count + ccr_pkg::WD_CNT_ONE;
      end
      // host writes; a write that sets a kick wins over its clear
      if (i_wr_en) begin
         case (i_addr)
            ccr_pkg::ADDR_INPUT_CURRENT: begin
               nxt_state.cfg.in_cur.optimizer_on =
                  wr_in_cur.optimizer_on; // R4
               nxt_state.cfg.in_cur.input_current_limit_code =
                  wr_in_cur.input_current_limit_code; // R6
               // kick only lives while the optimizer is on
               nxt_state.cfg.in_cur.optimizer_kick =
                  wr_in_cur.optimizer_on
                  & (nxt_state.cfg.in_cur.optimizer_kick
                  | wr_in_cur.optimizer_kick); // R2 R21
               nxt_state.cfg.in_cur.source_detect_kick =
                  nxt_state.cfg.in_cur.source_detect_kick
                  | wr_in_cur.source_detect_kick; // R3
            end
            ccr_pkg::ADDR_PRE_END_CURRENT: begin
               nxt_state.cfg.pre_end = i_wr_data; // R10
            end
            ccr_pkg::ADDR_CTRL_FIRST: begin
               nxt_state.cfg.ctrl1 = i_wr_data; // R12 R13 R15 R16 R17
            end
            ccr_pkg::ADDR_CTRL_SECOND: begin
               nxt_state.cfg.ctrl2 =
                  i_wr_data & ccr_pkg::RW_MASK_CTRL_SECOND; // R19
            end
            default: begin
               nxt_state.cfg = nxt_state.cfg; // unmapped write ignored
            end
         endcase
      end
      // read data held until the next read
      if (i_rd_en) begin
         nxt_state.rd_data = read_byte(i_addr, state_ff.cfg);
      end
      // safety timer slowed while a regulation loop is active
      nxt_state.timer_slow = state_ff.cfg.ctrl1.half_speed_timer_on
         & (i_input_reg | i_thermal_reg); // R17
      // register reset overrides the configuration and the watchdog, not the read data or the slow flag
      if (i_reg_rst) begin
         nxt_state.cfg = ccr_pkg::RST_CFG; // R1 R9 R11 R18 R20
         nxt_state.wd_count = '0;
         nxt_state.wd_expired = 1'b0;
      end
   end

   // state register
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= '{cfg: ccr_pkg::RST_CFG, default: '0}; // R1 R9 R11 R18
      end else begin
         state_ff <= nxt_state;
      end
   end

   // sources for the applied input current limit
   assign limit_src = {state_ff.cfg.in_cur.input_current_limit_code,
      i_opt_result_code, i_pin_limit_code, i_detect_limit_code};

   // minimum selector
   ccr_limit_min u_limit_min (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_codes(limit_src),
      .o_applied_code(o_applied_limit)
   );

   assign o_cfg = state_ff.cfg;
   assign o_rd_data = state_ff.rd_data;
   assign o_wd_expired = state_ff.wd_expired;
   assign o_timer_slow = state_ff.timer_slow;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   // helper: write to 03h
   logic wr03;
   assign wr03 = i_wr_en && (i_addr == ccr_pkg::ADDR_INPUT_CURRENT);

   // read byte seen with the second control layout
   ccr_pkg::ccr_ctrl_second_type rd_as_second;
   assign rd_as_second = o_rd_data;

   chk_regrst_defaults: assert property (i_reg_rst |=> // R1
      o_cfg == ccr_pkg::RST_CFG && o_cfg.ctrl2.auto_source_detect_on)
      else $error("register reset did not load defaults");

   chk_kick_needs_enable: assert property (wr03 && !i_reg_rst // R21
      && !wr_in_cur.optimizer_on |=> !o_cfg.in_cur.optimizer_kick)
      else $error("optimizer kick set while optimizer off");

   chk_kick_sets: assert property (wr03 && !i_reg_rst // R2
      && wr_in_cur.optimizer_on && wr_in_cur.optimizer_kick
      |=> o_cfg.in_cur.optimizer_kick)
      else $error("optimizer kick lost on write");

   chk_kick_clears: assert property (o_cfg.in_cur.optimizer_kick // R2
      && i_opt_started && !i_wr_en && !i_reg_rst
      |=> !o_cfg.in_cur.optimizer_kick ##1 (!o_cfg.in_cur.optimizer_kick
      || $past(i_wr_en) || $past(i_reg_rst)))
      else $error("optimizer kick did not clear on start");

   chk_detect_sets: assert property (wr03 && !i_reg_rst // R3
      && wr_in_cur.source_detect_kick
      |=> o_cfg.in_cur.source_detect_kick)
      else $error("detect kick lost on write");

   chk_wd_keeps_limit: assert property (o_wd_expired |-> // R5
      o_cfg.in_cur.input_current_limit_code
      == $past(o_cfg.in_cur.input_current_limit_code)
      && o_cfg.in_cur.optimizer_on == $past(o_cfg.in_cur.optimizer_on))
      else $error("watchdog changed kept fields");

   chk_wd_defaults: assert property (o_wd_expired |-> // R14
      o_cfg.ctrl1 == ccr_pkg::RST_CTRL_FIRST
      && o_cfg.pre_end == ccr_pkg::RST_PRE_END_CURRENT)
      else $error("watchdog expiry missed defaults");

   chk_wd_off_quiet: assert property ( // R14
      o_cfg.ctrl1.wd_period == ccr_pkg::CCR_WD_OFF |=> !o_wd_expired)
      else $error("watchdog expired while off");

   chk_reserved_zero: assert property (i_rd_en // R19
      && i_addr == ccr_pkg::ADDR_CTRL_SECOND
      |=> rd_as_second.reserved == 1'b0)
      else $error("reserved bit read back as one");

   chk_timer_slow: assert property (i_input_reg && !i_reg_rst // R17
      && o_cfg.ctrl1.half_speed_timer_on |=> o_timer_slow)
      else $error("safety timer not slowed");

   // a done pulse clears the detection kick
   chk_detect_clears: assert property ( // R3
      o_cfg.in_cur.source_detect_kick && i_detect_done
      && !i_wr_en && !i_reg_rst |=> !o_cfg.in_cur.source_detect_kick)
      else $error("detect kick did not clear");

   // limit code lands as written
   chk_limit_lands: assert property (wr03 && !i_reg_rst |=> // R6
      o_cfg.in_cur.input_current_limit_code
      == $past(wr_in_cur.input_current_limit_code))
      else $error("limit code write lost");

   // optimizer enable follows the write
   chk_opt_on_lands: assert property (wr03 && !i_reg_rst |=> // R4
      o_cfg.in_cur.optimizer_on == $past(wr_in_cur.optimizer_on))
      else $error("optimizer enable write lost");

   // current codes land as written
   chk_pre_end_lands: assert property (i_wr_en && !i_reg_rst // R10
      && i_addr == ccr_pkg::ADDR_PRE_END_CURRENT
      |=> o_cfg.pre_end == $past(i_wr_data))
      else $error("current code write lost");

   // first control register lands as written
   chk_ctrl_first_lands: assert property (i_wr_en && !i_reg_rst // R12
      && i_addr == ccr_pkg::ADDR_CTRL_FIRST
      |=> o_cfg.ctrl1 == $past(i_wr_data))
      else $error("control write lost");

   // reserved bit never stored
   chk_reserved_stored: assert property (!o_cfg.ctrl2.reserved) // R19
      else $error("reserved bit stored as one");

   // expiry lasts one cycle
   chk_expiry_pulse: assert property (o_wd_expired |=> !o_wd_expired) // R14
      else $error("watchdog expiry longer than a pulse");

   // no slowing while the half speed bit is clear
   chk_slow_needs_on: assert property ( // R17
      !o_cfg.ctrl1.half_speed_timer_on |=> !o_timer_slow)
      else $error("safety timer slowed while disabled");

   // thermal regulation slows the timer too
   chk_slow_thermal: assert property (i_thermal_reg // R17
      && o_cfg.ctrl1.half_speed_timer_on |=> o_timer_slow)
      else $error("safety timer not slowed in thermal loop");

   // register reset also drops the expiry pulse
   chk_regrst_quiet: assert property (i_reg_rst |=> !o_wd_expired) // R1
      else $error("expiry pulse after register reset");

   // a read of 05h returns the stored byte
   chk_read_first: assert property (i_rd_en // R11
      && i_addr == ccr_pkg::ADDR_CTRL_FIRST
      |=> o_rd_data == $past(o_cfg.ctrl1))
      else $error("read of first control wrong");

   // a read of 03h returns the stored byte
   chk_read_input: assert property (i_rd_en // R1
      && i_addr == ccr_pkg::ADDR_INPUT_CURRENT
      |=> o_rd_data == $past(o_cfg.in_cur))
      else $error("read of input current wrong");

   cov_kick_start: cover property (wr03 && wr_in_cur.optimizer_kick
      ##[1:8] i_opt_started);
   cov_wd_expiry: cover property (o_wd_expired);
   cov_read_second: cover property (i_rd_en
      && i_addr == ccr_pkg::ADDR_CTRL_SECOND);
   cov_pin_limits: cover property (o_applied_limit
      < o_cfg.in_cur.input_current_limit_code);
   cov_reg_reset: cover property (i_reg_rst);

endmodule // ccr_regs

`default_nettype wire

// file: ccr_pkg.sv
// constants, layouts and types of the charger control register bank
//
// Overview of operation
// R1: input current register at 03h, reset 39h
// R2: optimizer kick settable only, clears on start
// R3: source detect kick defaults 0, forces detection
// R4: optimizer on bit enables optimizer, default 1
// R5: watchdog keeps optimizer on and limit code
// R6: limit code is 500 mA plus 100 mA steps
// R7: limit codes above 1Ch act as 3300 mA
// R8: applied limit is minimum of four sources
// R9: precharge and end current register 04h, 22h
// R10: two 4-bit current codes, 50 mA steps
// R11: first control register at 05h, reset 9Dh
// R12: bit 7 enables charge termination, default on
// R13: bit 6 disables charge status indicator pin
// R14: watchdog period off, 40, 80, 160 s
// R15: bit 3 enables charging safety timer
// R16: fast charge duration 5, 8, 12, 20 h
// R17: half speed timer during input or thermal regulation
// R18: second control register at 06h, reset 7Dh
// R19: reserved bit 7 of 06h reads 0
// R20: automatic source detection defaults on
// R21: kick write ignored while optimizer is off
// R22: host must access within watchdog period

package ccr_pkg;

   // register addresses
   localparam logic [7:0] ADDR_INPUT_CURRENT = 8'h03;
   localparam logic [7:0] ADDR_PRE_END_CURRENT = 8'h04;
   localparam logic [7:0] ADDR_CTRL_FIRST = 8'h05;
   localparam logic [7:0] ADDR_CTRL_SECOND = 8'h06;
   localparam logic [7:0] READ_UNMAPPED = 8'h00; // answer to other addresses

   // input current register layout
   typedef struct packed {
      logic optimizer_kick;
      logic source_detect_kick;
      logic optimizer_on;
      logic [4:0] input_current_limit_code;
   } ccr_input_current_type;

   // precharge and termination current layout
   typedef struct packed {
      logic [3:0] precharge_current_code;
      logic [3:0] end_of_charge_current_code;
   } ccr_pre_end_type;

   // watchdog period codes
   typedef enum logic [1:0] {
      CCR_WD_OFF = 2'h0,
      CCR_WD_40S = 2'h1,
      CCR_WD_80S = 2'h2,
      CCR_WD_160S = 2'h3
   } ccr_wd_period_type;

   // fast charge duration codes
   typedef enum logic [1:0] {
      CCR_FC_5H = 2'h0,
      CCR_FC_8H = 2'h1,
      CCR_FC_12H = 2'h2,
      CCR_FC_20H = 2'h3
   } ccr_fc_duration_type;

   // first charger control layout
   typedef struct packed {
      logic termination_on;
      logic indicator_pin_off;
      ccr_wd_period_type wd_period;
      logic safety_timer_on;
      ccr_fc_duration_type fast_charge_duration;
      logic half_speed_timer_on;
   } ccr_ctrl_first_type;

   // second charger control layout
   typedef struct packed {
      logic reserved;
      logic auto_source_detect_on;
      logic [1:0] thermal_threshold;
      logic charging_on;
      logic precharge_cutoff;
      logic [1:0] recharge_offset;
   } ccr_ctrl_second_type;

   // all host visible configuration
   typedef struct packed {
      ccr_input_current_type in_cur;
      ccr_pre_end_type pre_end;
      ccr_ctrl_first_type ctrl1;
      ccr_ctrl_second_type ctrl2;
   } ccr_cfg_type;

   // reset values
   localparam ccr_input_current_type RST_INPUT_CURRENT = 8'h39;
   localparam ccr_pre_end_type RST_PRE_END_CURRENT = 8'h22;
   localparam ccr_ctrl_first_type RST_CTRL_FIRST = 8'h9D;
   localparam ccr_ctrl_second_type RST_CTRL_SECOND = 8'h7D;
   localparam ccr_cfg_type RST_CFG = {RST_INPUT_CURRENT,
      RST_PRE_END_CURRENT, RST_CTRL_FIRST, RST_CTRL_SECOND};

   // bits that return to default on watchdog expiry
   localparam logic [7:0] WD_MASK_INPUT_CURRENT = 8'hC0;
   localparam logic [7:0] WD_MASK_PRE_END_CURRENT = 8'hFF;
   localparam logic [7:0] WD_MASK_CTRL_FIRST = 8'hFF;
   localparam logic [7:0] WD_MASK_CTRL_SECOND = 8'hFC;
   // writable and readable bits of the second control register
   localparam logic [7:0] RW_MASK_CTRL_SECOND = 8'h7F;

   // input current limit coding
   localparam int LIMIT_W = 5;
   localparam logic [4:0] LIMIT_MAX_CODE = 5'h1C; // 3300 mA
   localparam int LIMIT_OFFSET_MA = 500;
   localparam int LIMIT_STEP_MA = 100;
   localparam int LIMIT_SRC_N = 4; // register, optimizer, pin, detection
   typedef logic [LIMIT_SRC_N-1:0][LIMIT_W-1:0] ccr_limit_src_type;

   // watchdog timing
   localparam int CLK_HZ = 100_000_000;
   localparam int WD_BASE_S = 40;
   localparam int WD_CNT_W = 36;
   localparam logic [WD_CNT_W-1:0] WD_BASE_CYCLES =
      WD_CNT_W'(64'(WD_BASE_S) * 64'(CLK_HZ));
   localparam logic [WD_CNT_W-1:0] WD_CNT_ONE = 36'h1;

   // registered state of the bank
   typedef struct packed {
      ccr_cfg_type cfg;
      logic [WD_CNT_W-1:0] wd_count;
      logic wd_expired;
      logic [7:0] rd_data;
      logic timer_slow;
   } ccr_core_state_type;

endpackage

// file: ccr_limit_min.sv
// applied input current limit: smallest of four clamped limit codes
`timescale 1ns/100ps
`default_nettype none

module ccr_limit_min (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire ccr_pkg::ccr_limit_src_type i_codes,
   output logic [ccr_pkg::LIMIT_W-1:0] o_applied_code
);

   // codes past the top step act as the top step
   function automatic logic [ccr_pkg::LIMIT_W-1:0] clamp_code(
      input logic [ccr_pkg::LIMIT_W-1:0] code);
      clamp_code = (code > ccr_pkg::LIMIT_MAX_CODE) ?
         ccr_pkg::LIMIT_MAX_CODE : code; // R7
   endfunction

   logic [ccr_pkg::LIMIT_W-1:0] state_ff; // applied code
   logic [ccr_pkg::LIMIT_W-1:0] nxt_state;

   // running minimum over all sources
   always_comb begin
      nxt_state = ccr_pkg::LIMIT_MAX_CODE;
      for (int i = 0; i < ccr_pkg::LIMIT_SRC_N; i++) begin
         if (clamp_code(i_codes[i]) < nxt_state) begin
            nxt_state = clamp_code(i_codes[i]); // R8
         end
      end
   end

   // register the result
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= ccr_pkg::RST_INPUT_CURRENT.input_current_limit_code;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_applied_code = state_ff;

   // applied code never exceeds any clamped source
   property p_min_le_each;
      @(posedge i_core_clk) disable iff (!i_nrst)
      1'b1 |=> (o_applied_code <= clamp_code($past(i_codes[0])))
         && (o_applied_code <= clamp_code($past(i_codes[1])))
         && (o_applied_code <= clamp_code($past(i_codes[2])))
         && (o_applied_code <= clamp_code($past(i_codes[3])));
   endproperty
   chk_min_limit_le: assert property (p_min_le_each) // R8
      else $error("applied limit above a source");

   // applied code is one of the clamped sources
   chk_min_from_source: assert property (@(posedge i_core_clk)
      disable iff (!i_nrst)
      1'b1 |=> (o_applied_code == clamp_code($past(i_codes[0])))
         || (o_applied_code == clamp_code($past(i_codes[1])))
         || (o_applied_code == clamp_code($past(i_codes[2])))
         || (o_applied_code == clamp_code($past(i_codes[3])))) // R8
      else $error("applied limit matches no source");

   // top code bound holds always
   chk_limit_clamp: assert property (@(posedge i_core_clk)
      disable iff (!i_nrst)
      o_applied_code <= ccr_pkg::LIMIT_MAX_CODE) // R7
      else $error("applied limit above top step");

endmodule // ccr_limit_min

`default_nettype wire

// file: ccr_host_model.sv
// host side model that drives the register byte strobes
`timescale 1ns/100ps
`default_nettype none

module ccr_host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_rd_data,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wr_data
);
   // idle bus from time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end

   // one byte write, held up to its taking edge
   // each access restarts the device's host watchdog
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_wr_en = 1'b0;
      o_addr = ~a; // released lines stop showing the old value
      o_wr_data = ~d;
   endtask

   // one byte read, data taken once the answer has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_addr = a;
      o_rd_en = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_rd_en = 1'b0;
      o_addr = ~a;
      @(posedge i_core_clk);
      #1;
      d = i_rd_data;
   endtask
endmodule // ccr_host_model

`default_nettype wire

// file: ccr_regs_tb.sv
// self-checking bench of the charger control register bank
`timescale 1ns/100ps
`default_nettype none

module ccr_regs_tb;
   localparam int WD_P = 40; // shortened watchdog base period
   logic i_core_clk;
   logic i_nrst;
   logic i_reg_rst;
   logic i_opt_started;
   logic i_detect_done;
   logic [4:0] i_opt_result_code;
   logic [4:0] i_pin_limit_code;
   logic [4:0] i_detect_limit_code;
   logic i_input_reg;
   logic i_thermal_reg;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [7:0] wr_data;
   ccr_pkg::ccr_cfg_type o_cfg;
   logic [7:0] o_rd_data;
   logic [4:0] o_applied_limit;
   logic o_wd_expired;
   logic o_timer_slow;
   int mismatches;
   int checks;

   // block under test with a short watchdog
   ccr_regs #(.WD_BASE_CYCLES(36'h28)) dut (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_rst(i_reg_rst),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
      .i_wr_data(wr_data), .i_opt_started(i_opt_started),
      .i_detect_done(i_detect_done),
      .i_opt_result_code(i_opt_result_code),
      .i_pin_limit_code(i_pin_limit_code),
      .i_detect_limit_code(i_detect_limit_code),
      .i_input_reg(i_input_reg), .i_thermal_reg(i_thermal_reg),
      .o_cfg(o_cfg), .o_rd_data(o_rd_data),
      .o_applied_limit(o_applied_limit), .o_wd_expired(o_wd_expired),
      .o_timer_slow(o_timer_slow)
   );

   // host on the register strobes
   ccr_host_model u_host (
      .i_core_clk(i_core_clk), .i_rd_data(o_rd_data), .o_wr_en(wr_en),
      .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data)
   );

   // 100 MHz clock
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // compare one byte and count it
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      u_host.rd(a, v);
      chk($sformatf("read_%h", a), e, v);
   endtask

   // let n edges pass, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask

   // one cycle pulse on a strobe input
   task automatic pulse(ref logic s);
      @(posedge i_core_clk);
      #1;
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask

   // reset values on outputs and through reads
   task automatic t_reset();
      chk("cfg_in", 8'h39, o_cfg[31:24]);
      chk("cfg_pe", 8'h22, o_cfg[23:16]);
      chk("cfg_c1", 8'h9D, o_cfg[15:8]);
      chk("cfg_c2", 8'h7D, o_cfg[7:0]);
      chk("applied", 8'h19, {3'h0, o_applied_limit});
      rchk(8'h03, 8'h39);
      rchk(8'h04, 8'h22);
      rchk(8'h05, 8'h9D);
      rchk(8'h06, 8'h7D);
      rchk(8'h07, 8'h00);
   endtask

   // expiry timing per period and which fields fall back
   task automatic t_watchdog();
      int n;
      int e;
      for (int k = 1; k <= 3; k++) begin
         u_host.wr(8'h03, 8'h25);
         u_host.wr(8'h04, 8'hA5);
         u_host.wr(8'h06, 8'h03);
         u_host.wr(8'h05, {2'b10, 2'(k), 4'hD});
         e = WD_P * (1 << (k - 1));
         n = 0;
         while (o_wd_expired !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
         end
         checks++;
         if (n != e) begin
            mismatches++;
            $display("BAD wd_span expected %0d seen %0d", e, n);
         end
         cyc(1);
         chk("wd_in", 8'h25, o_cfg[31:24]);
         chk("wd_pe", 8'h22, o_cfg[23:16]);
         chk("wd_c1", 8'h9D, o_cfg[15:8]);
         chk("wd_c2", 8'h7F, o_cfg[7:0]);
      end
   endtask

   // plain fields, watchdog off, reserved bit
   task automatic t_fields();
      u_host.wr(8'h05, 8'h4F);
      rchk(8'h05, 8'h4F);
      chk("term", 8'h00, {7'h0, o_cfg.ctrl1.termination_on});
      chk("ind", 8'h01, {7'h0, o_cfg.ctrl1.indicator_pin_off});
      chk("safe", 8'h01, {7'h0, o_cfg.ctrl1.safety_timer_on});
      chk("dur", 8'h03, {6'h0, o_cfg.ctrl1.fast_charge_duration});
      u_host.wr(8'h04, 8'hA5);
      rchk(8'h04, 8'hA5);
      u_host.wr(8'h06, 8'hFF);
      rchk(8'h06, 8'h7F);
      u_host.wr(8'h06, 8'h00);
      rchk(8'h06, 8'h00);
      u_host.wr(8'h07, 8'h55);
      rchk(8'h04, 8'hA5);
   endtask

   // optimizer and source detection kicks
   task automatic t_kicks();
      u_host.wr(8'h03, 8'hA0);
      u_host.wr(8'h03, 8'h20);
      rchk(8'h03, 8'hA0);
      pulse(i_opt_started);
      rchk(8'h03, 8'h20);
      u_host.wr(8'h03, 8'h80);
      rchk(8'h03, 8'h00);
      chk("opt_on", 8'h00, {7'h0, o_cfg.in_cur.optimizer_on});
      u_host.wr(8'h03, 8'h60);
      rchk(8'h03, 8'h60);
      pulse(i_detect_done);
      rchk(8'h03, 8'h20);
   endtask

   // applied limit is the least of four clamped codes
   task automatic t_limit();
      logic [4:0] tv [5][5] = '{
         '{5'h1F, 5'h1E, 5'h1D, 5'h1F, 5'h1C},
         '{5'h05, 5'h1F, 5'h1F, 5'h1F, 5'h05},
         '{5'h1F, 5'h0A, 5'h1F, 5'h1F, 5'h0A},
         '{5'h1F, 5'h1F, 5'h03, 5'h1F, 5'h03},
         '{5'h1F, 5'h1F, 5'h1F, 5'h07, 5'h07}};
      for (int i = 0; i < 5; i++) begin
         i_opt_result_code = tv[i][1];
         i_pin_limit_code = tv[i][2];
         i_detect_limit_code = tv[i][3];
         u_host.wr(8'h03, {3'h1, tv[i][0]});
         cyc(2);
         chk("applied", {3'h0, tv[i][4]}, {3'h0, o_applied_limit});
      end
   endtask

   // half speed timer flag follows regulation
   task automatic t_slow();
      i_input_reg = 1'b1;
      cyc(2);
      chk("slow_in", 8'h01, {7'h0, o_timer_slow});
      i_input_reg = 1'b0;
      i_thermal_reg = 1'b1;
      cyc(2);
      chk("slow_th", 8'h01, {7'h0, o_timer_slow});
      u_host.wr(8'h05, 8'h4E);
      cyc(2);
      chk("slow_off", 8'h00, {7'h0, o_timer_slow});
      i_thermal_reg = 1'b0;
   endtask

   // register reset restores the defaults of 03h, 05h and 06h
   task automatic t_regrst();
      u_host.wr(8'h03, 8'h2A);
      pulse(i_reg_rst);
      chk("rr_in", 8'h39, o_cfg[31:24]);
      chk("rr_c1", 8'h9D, o_cfg[15:8]);
      rchk(8'h06, 8'h7D);
   endtask

   // final counts and verdict
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      mismatches = 0;
      checks = 0;
      i_nrst = 1'b0;
      i_reg_rst = 1'b0;
      i_opt_started = 1'b0;
      i_detect_done = 1'b0;
      i_opt_result_code = 5'h1F;
      i_pin_limit_code = 5'h1F;
      i_detect_limit_code = 5'h1F;
      i_input_reg = 1'b0;
      i_thermal_reg = 1'b0;
      cyc(6);
      i_nrst = 1'b1;
      t_reset();
      t_watchdog();
      t_fields();
      t_kicks();
      t_limit();
      t_slow();
      t_regrst();
      end_of_test();
   end

   // hang guard
   initial begin
      #100000;
      mismatches++;
      $display("BAD run_time expected done seen hang");
      end_of_test();
   end
endmodule // ccr_regs_tb

`default_nettype wire
